// File: design/ecf_pkg.sv
// Shared constants and types for the extended context entry request filter
package ecf_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_ENTRY = 8'h00;
  localparam logic [7:0] OFS_BASE = 8'h04;
  localparam logic [7:0] OFS_CAP = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_FCOUNT = 8'h14;
  localparam logic [7:0] OFS_LAST = 8'h18;

  // Entry field positions
  localparam int PRESENT_BIT = 0;
  localparam int MUTE_BIT = 1;
  localparam int TYPE_LSB = 2;
  localparam int TYPE_MSB = 4;
  localparam int PIDE_BIT = 11;
  localparam int BASE_LSB = 12;
  localparam int CAP_ID_ONLY_BIT = 0;

  // Writable bits of the entry and base registers
  localparam logic [31:0] ENTRY_WMASK = 32'h0000_081f;
  localparam logic [31:0] BASE_WMASK = 32'hffff_f000;

  // Translation type encodings handled here
  localparam logic [2:0] TYPE_ID_NOTLB = 3'h6;
  localparam logic [2:0] TYPE_ID_TLB = 3'h7;

  // Status and mask bit positions
  localparam int ST_BLOCK = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_MUTED = 2;
  localparam int ST_RESV = 3;
  localparam int ST_W = 4;

  // Last fault record layout
  localparam int LAST_PID_LSB = 0;
  localparam int LAST_KIND_LSB = 20;
  localparam int LAST_HASPID_BIT = 22;
  localparam int LAST_NOTPRES_BIT = 23;
  localparam int LAST_RESV_BIT = 24;

  // Reset values
  localparam logic [31:0] ENTRY_RST = 32'h0000_0000;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  localparam logic [ST_W-1:0] STATUS_RST = 4'h0;
  localparam logic [ST_W-1:0] MASK_RST = 4'h0;
  localparam logic [15:0] FCOUNT_RST = 16'h0000;
  localparam logic [15:0] FCOUNT_MAX = 16'hffff;

  localparam int PID_W = 20;
  localparam int BASE_W = 20;

  typedef enum logic [1:0] {
    KIND_UNTRANS = 2'h0,
    KIND_XLATE = 2'h1,
    KIND_DONE = 2'h2
  } ecf_kind_e;

  typedef enum logic [1:0] {
    ACT_BLOCK = 2'h0,
    ACT_REMAP = 2'h1,
    ACT_PASS = 2'h2,
    ACT_DEFER = 2'h3
  } ecf_act_e;

  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic has_pid;
    logic [PID_W-1:0] pid;
  } ecf_req_s;

  typedef struct packed {
    logic valid;
    ecf_act_e action;
    logic fault;
    logic muted;
    logic [BASE_W-1:0] base;
    logic [PID_W-1:0] pid;
  } ecf_resp_s;

  typedef struct packed {
    ecf_act_e action;
    logic fault;
    logic report;
    logic not_present;
    logic reserved;
  } ecf_verdict_s;

endpackage : ecf_pkg

// File: design/ecf_sync.sv
// Three-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module ecf_sync (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic level_o
);

  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } ecf_sync_s;

  ecf_sync_s state;
  ecf_sync_s next_state;

  always_comb begin
    next_state = state;
    next_state.stage = {state.stage[1:0], async_i};
    // Second and third stage must agree before the level moves
    if (state.stage[1] == state.stage[2]) begin
      next_state.level = state.stage[2];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level_o = state.level;

endmodule : ecf_sync

// File: design/ecf_decode.sv
// Per-request verdict from the entry control fields
`timescale 1ns/1ps
module ecf_decode (
  input wire logic [31:0] entry_i,
  input wire logic id_only_capable_i,
  input wire ecf_pkg::ecf_req_s req_i,
  output ecf_pkg::ecf_verdict_s verdict_o
);

  logic present;
  logic mute;
  logic process_id_enable;
  logic [2:0] ttype;
  logic id_only;

  always_comb begin
    present = entry_i[ecf_pkg::PRESENT_BIT];
    mute = entry_i[ecf_pkg::MUTE_BIT];
    process_id_enable = entry_i[ecf_pkg::PIDE_BIT];
    ttype = entry_i[ecf_pkg::TYPE_MSB:ecf_pkg::TYPE_LSB];
    id_only = (ttype == ecf_pkg::TYPE_ID_NOTLB) || (ttype == ecf_pkg::TYPE_ID_TLB);
    verdict_o.action = ecf_pkg::ACT_BLOCK;
    verdict_o.not_present = 1'b0;
    verdict_o.reserved = 1'b0;
    if (!present) begin
      verdict_o.not_present = 1'b1;
    end else if (id_only && (!id_only_capable_i || !process_id_enable)) begin
      // Reserved encoding is a property of the entry, whatever the request carries
      verdict_o.reserved = 1'b1;
    end else if (req_i.has_pid && !process_id_enable) begin
      verdict_o.action = ecf_pkg::ACT_BLOCK;
    end else if (ttype == ecf_pkg::TYPE_ID_NOTLB) begin
      unique case (req_i.kind)
        ecf_pkg::KIND_UNTRANS: begin
          verdict_o.action = req_i.has_pid ? ecf_pkg::ACT_REMAP : ecf_pkg::ACT_BLOCK;
        end
        default: begin
          verdict_o.action = ecf_pkg::ACT_BLOCK;
        end
      endcase
    end else if (ttype == ecf_pkg::TYPE_ID_TLB) begin
      unique case (req_i.kind)
        ecf_pkg::KIND_UNTRANS, ecf_pkg::KIND_XLATE: begin
          verdict_o.action = req_i.has_pid ? ecf_pkg::ACT_REMAP : ecf_pkg::ACT_BLOCK;
        end
        ecf_pkg::KIND_DONE: begin
          verdict_o.action = ecf_pkg::ACT_PASS;
        end
        default: begin
          verdict_o.action = ecf_pkg::ACT_BLOCK;
        end
      endcase
    end else begin
      // Other encodings go to the rest of the remapping path
      verdict_o.action = ecf_pkg::ACT_DEFER;
    end
    verdict_o.fault = (verdict_o.action == ecf_pkg::ACT_BLOCK);
    verdict_o.report = verdict_o.fault && !mute;
  end

endmodule : ecf_decode

// File: design/ecf_filter.sv
// Extended context entry request filter with Avalon-MM register slave
// Behaviour
// - Type 110b blocks untranslated requests without ID
// - Type 110b remaps untranslated requests with ID
// - Type 110b blocks translation and translated requests
// - Type 111b blocks no-ID untranslated and translation requests
// - Type 111b remaps ID-carrying untranslated and translation requests
// - Type 111b passes translated requests untouched
// - ID-only types reserved without capability or enable
// - Mute bit clear: faults recorded and reported
// - Mute bit set: faults neither recorded nor reported
// - Mute bit honoured even when entry absent
// - Present clear: entry absent, only mute used
// - Present set: type and controls take effect
// - Process ID enable clear blocks ID-carrying requests
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module ecf_filter (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic id_only_capable_i,
  input wire ecf_pkg::ecf_req_s req_i,
  output ecf_pkg::ecf_resp_s resp_o,
  output logic irq_o
);

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } ecf_bus_e;

  typedef struct packed {
    ecf_bus_e bus;
    logic waitreq;
    logic [31:0] rdata;
    logic [31:0] entry;
    logic [31:0] base;
    logic [ecf_pkg::ST_W-1:0] status;
    logic [ecf_pkg::ST_W-1:0] mask;
    logic [15:0] fcount;
    logic [31:0] last;
    ecf_pkg::ecf_resp_s resp;
    logic irq;
  } ecf_filter_s;

  ecf_filter_s state;
  ecf_filter_s next_state;

  logic cap_sync;
  ecf_pkg::ecf_verdict_s verdict;

  logic [31:0] be_mask;
  logic [31:0] rd_word;
  logic wr_take;
  logic rd_take;
  logic [ecf_pkg::ST_W-1:0] st_set;
  logic [ecf_pkg::ST_W-1:0] st_clr;
  logic [31:0] fault_rec;

  ecf_sync u_cap_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(id_only_capable_i),
    .level_o(cap_sync)
  );

  ecf_decode u_decode (
    .entry_i(state.entry),
    .id_only_capable_i(cap_sync),
    .req_i(req_i),
    .verdict_o(verdict)
  );

  // Byte enables widened to a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_be
      assign be_mask[gi*8 +: 8] = {8{avs_byteenable_i[gi]}};
    end
  endgenerate

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (avs_address_i)
      ecf_pkg::OFS_ENTRY: begin
        rd_word = state.entry;
      end
      ecf_pkg::OFS_BASE: begin
        rd_word = state.base;
      end
      ecf_pkg::OFS_CAP: begin
        rd_word[ecf_pkg::CAP_ID_ONLY_BIT] = cap_sync;
      end
      ecf_pkg::OFS_STATUS: begin
        rd_word[ecf_pkg::ST_W-1:0] = state.status;
      end
      ecf_pkg::OFS_MASK: begin
        rd_word[ecf_pkg::ST_W-1:0] = state.mask;
      end
      ecf_pkg::OFS_FCOUNT: begin
        rd_word[15:0] = state.fcount;
      end
      ecf_pkg::OFS_LAST: begin
        rd_word = state.last;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Fault record of the request under decision
  always_comb begin
    fault_rec = 32'h0000_0000;
    fault_rec[ecf_pkg::LAST_PID_LSB +: ecf_pkg::PID_W] = req_i.pid;
    fault_rec[ecf_pkg::LAST_KIND_LSB +: 2] = req_i.kind;
    fault_rec[ecf_pkg::LAST_HASPID_BIT] = req_i.has_pid;
    fault_rec[ecf_pkg::LAST_NOTPRES_BIT] = verdict.not_present;
    fault_rec[ecf_pkg::LAST_RESV_BIT] = verdict.reserved;
  end

  // Status events from the request just decided
  always_comb begin
    st_set = '0;
    if (req_i.valid) begin
      st_set[ecf_pkg::ST_BLOCK] = verdict.fault;
      st_set[ecf_pkg::ST_FAULT] = verdict.report;
      st_set[ecf_pkg::ST_MUTED] = verdict.fault && !verdict.report;
      st_set[ecf_pkg::ST_RESV] = verdict.reserved;
    end
  end

  always_comb begin
    wr_take = (state.bus == BUS_ACK) && avs_write_i;
    rd_take = (state.bus == BUS_IDLE) && avs_read_i;
    st_clr = '0;
    if (wr_take && (avs_address_i == ecf_pkg::OFS_STATUS)) begin
      st_clr = avs_writedata_i[ecf_pkg::ST_W-1:0] & be_mask[ecf_pkg::ST_W-1:0];
    end
  end

  always_comb begin
    next_state = state;

    // Bus handshake: one wait cycle, answer on the second
    unique case (state.bus)
      BUS_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          next_state.bus = BUS_ACK;
          next_state.waitreq = 1'b0;
        end
      end
      BUS_ACK: begin
        next_state.bus = BUS_IDLE;
        next_state.waitreq = 1'b1;
      end
      default: begin
        next_state.bus = BUS_IDLE;
        next_state.waitreq = 1'b1;
      end
    endcase
    if (rd_take) begin
      next_state.rdata = rd_word;
    end

    // Register writes
    if (wr_take) begin
      unique case (avs_address_i)
        ecf_pkg::OFS_ENTRY: begin
          next_state.entry = (state.entry & ~(be_mask & ecf_pkg::ENTRY_WMASK))
            | (avs_writedata_i & be_mask & ecf_pkg::ENTRY_WMASK);
        end
        ecf_pkg::OFS_BASE: begin
          next_state.base = (state.base & ~(be_mask & ecf_pkg::BASE_WMASK))
            | (avs_writedata_i & be_mask & ecf_pkg::BASE_WMASK);
        end
        ecf_pkg::OFS_MASK: begin
          next_state.mask = (state.mask & ~be_mask[ecf_pkg::ST_W-1:0])
            | (avs_writedata_i[ecf_pkg::ST_W-1:0] & be_mask[ecf_pkg::ST_W-1:0]);
        end
        default: begin
          next_state.mask = state.mask;
        end
      endcase
    end

    // Sticky status: a new event wins over a clear in the same cycle
    next_state.status = (state.status & ~st_clr) | st_set;

    // Fault logging only for reported faults
    if (req_i.valid && verdict.report) begin
      next_state.last = fault_rec;
      if (state.fcount != ecf_pkg::FCOUNT_MAX) begin
        next_state.fcount = state.fcount + 16'h0001;
      end
    end

    // Response, one cycle after the request
    next_state.resp.valid = req_i.valid;
    next_state.resp.action = verdict.action;
    next_state.resp.fault = req_i.valid && verdict.report;
    next_state.resp.muted = req_i.valid && verdict.fault && !verdict.report;
    next_state.resp.pid = req_i.pid;
    next_state.resp.base = '0;
    if (verdict.action == ecf_pkg::ACT_REMAP) begin
      // Table base travels with remapped requests
      next_state.resp.base = state.base[31:ecf_pkg::BASE_LSB];
    end

    next_state.irq = |(next_state.status & next_state.mask);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state.bus <= BUS_IDLE;
      state.waitreq <= 1'b1;
      state.rdata <= 32'h0000_0000;
      state.entry <= ecf_pkg::ENTRY_RST;
      state.base <= ecf_pkg::BASE_RST;
      state.status <= ecf_pkg::STATUS_RST;
      state.mask <= ecf_pkg::MASK_RST;
      state.fcount <= ecf_pkg::FCOUNT_RST;
      state.last <= 32'h0000_0000;
      state.resp <= '0;
      state.irq <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign avs_readdata_o = state.rdata;
  assign avs_waitrequest_o = state.waitreq;
  assign resp_o = state.resp;
  assign irq_o = state.irq;

endmodule : ecf_filter

// File: testbench/ecf_filter_checker.sv
// Port-level assertions for the request filter
`timescale 1ns/1ps
module ecf_filter_checker (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire ecf_pkg::ecf_req_s req_i,
  input wire ecf_pkg::ecf_resp_s resp_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_resp_lat; req_i.valid |=> resp_o.valid; endproperty
  a_resp_lat: assert property (p_resp_lat) else $error("response missing");
  property p_resp_cause; resp_o.valid |-> $past(req_i.valid); endproperty
  a_resp_cause: assert property (p_resp_cause) else $error("stray response");
  property p_pid_echo; resp_o.valid |-> resp_o.pid == $past(req_i.pid); endproperty
  a_pid_echo: assert property (p_pid_echo) else $error("pid not echoed");
  property p_block_fault;
    resp_o.valid && resp_o.action == ecf_pkg::ACT_BLOCK |-> resp_o.fault != resp_o.muted;
  endproperty
  a_block_fault: assert property (p_block_fault) else $error("block without fault");
  property p_clean;
    resp_o.valid && resp_o.action != ecf_pkg::ACT_BLOCK |-> !resp_o.fault && !resp_o.muted;
  endproperty
  a_clean: assert property (p_clean) else $error("fault on allowed request");
  property p_remap_src;
    resp_o.valid && resp_o.action == ecf_pkg::ACT_REMAP
      |-> $past(req_i.has_pid) && $past(req_i.kind) != ecf_pkg::KIND_DONE;
  endproperty
  a_remap_src: assert property (p_remap_src) else $error("bad remap");
  property p_pass_src;
    resp_o.valid && resp_o.action == ecf_pkg::ACT_PASS |-> $past(req_i.kind) == ecf_pkg::KIND_DONE;
  endproperty
  a_pass_src: assert property (p_pass_src) else $error("bad pass");
  property p_base_zero;
    resp_o.valid && resp_o.action != ecf_pkg::ACT_REMAP |-> resp_o.base == '0;
  endproperty
  a_base_zero: assert property (p_base_zero) else $error("base leaked");
  property p_wait_answer; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("bus answer late");
  property p_wait_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer too long");
endmodule : ecf_filter_checker

// File: testbench/ecf_endpoint.sv
// Endpoint model issuing one request per fire pulse
`timescale 1ns/1ps
module ecf_endpoint (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic fire_i,
  input wire ecf_pkg::ecf_req_s cmd_i,
  output ecf_pkg::ecf_req_s req_o
);
  // Idle payload toggles so stale fields never look live
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_o <= '0;
    end else if (fire_i) begin
      req_o <= cmd_i;
    end else begin
      req_o <= {1'h0, ~req_o[22:0]};
    end
  end
endmodule : ecf_endpoint

// File: testbench/ecf_filter_bench.sv
// Self-checking bench for the request filter
`timescale 1ns/1ps
`define ECF_CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module ecf_filter_bench;
  typedef struct packed {
    logic [11:0] entry; logic [1:0] kind; logic pid; logic [1:0] act; logic fault; logic muted;
  } ecf_row_s;
  localparam ecf_row_s ROWS [14] = '{
    '{12'h819, 2'h0, 1'h0, 2'h0, 1'h1, 1'h0}, '{12'h819, 2'h0, 1'h1, 2'h1, 1'h0, 1'h0},
    '{12'h819, 2'h1, 1'h1, 2'h0, 1'h1, 1'h0}, '{12'h819, 2'h2, 1'h0, 2'h0, 1'h1, 1'h0},
    '{12'h81d, 2'h0, 1'h0, 2'h0, 1'h1, 1'h0}, '{12'h81d, 2'h1, 1'h0, 2'h0, 1'h1, 1'h0},
    '{12'h81d, 2'h1, 1'h1, 2'h1, 1'h0, 1'h0}, '{12'h81d, 2'h2, 1'h0, 2'h2, 1'h0, 1'h0},
    '{12'h01d, 2'h0, 1'h1, 2'h0, 1'h1, 1'h0}, '{12'h81c, 2'h2, 1'h0, 2'h0, 1'h1, 1'h0},
    '{12'h81e, 2'h2, 1'h0, 2'h0, 1'h0, 1'h1}, '{12'h81f, 2'h0, 1'h0, 2'h0, 1'h0, 1'h1},
    '{12'h001, 2'h0, 1'h1, 2'h0, 1'h1, 1'h0}, '{12'h801, 2'h0, 1'h0, 2'h3, 1'h0, 1'h0}};
  logic sys_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'h0;
  logic avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic id_only_capable_i = 1'h1;
  logic irq_o;
  logic fire = 1'h0;
  ecf_pkg::ecf_req_s cmd = '0;
  ecf_pkg::ecf_req_s req;
  ecf_pkg::ecf_resp_s resp;
  logic [31:0] rd;
  int failures = 0;
  int checks_done = 0;
  int nfault = 0;
  initial forever #20 sys_clk_i = ~sys_clk_i;
  ecf_endpoint i_ecf_endpoint (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .fire_i(fire),
    .cmd_i(cmd), .req_o(req));
  ecf_filter i_ecf_filter (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .id_only_capable_i(id_only_capable_i), .req_i(req), .resp_o(resp), .irq_o(irq_o));
  task end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'h0);
    rd = avs_readdata_o;
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
  endtask : bus
  task send(input logic [1:0] k, input logic p);
    @(posedge sys_clk_i);
    cmd <= '{1'h1, k, p, 20'h12345};
    fire <= 1'h1;
    @(posedge sys_clk_i);
    fire <= 1'h0;
    for (int n = 0; n < 8; n++) begin
      @(posedge sys_clk_i);
      if (resp.valid === 1'h1) break;
    end
  endtask : send
  initial begin
    #200000;
    failures++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge sys_clk_i);
    `ECF_CHK(avs_waitrequest_o, 1'h1)
    `ECF_CHK(irq_o, 1'h0)
    rst_n_i <= 1'h1;
    for (int a = 0; a < 8; a++) begin
      bus(1'h0, 8'(a * 4), 32'h0);
      `ECF_CHK(rd, (a == 2) ? 32'h1 : 32'h0)
    end
    $display("test reset values done");
    bus(1'h1, ecf_pkg::OFS_BASE, 32'habcde000);
    foreach (ROWS[i]) begin
      bus(1'h1, ecf_pkg::OFS_ENTRY, {20'h0, ROWS[i].entry});
      send(ROWS[i].kind, ROWS[i].pid);
      `ECF_CHK(resp.action, ROWS[i].act)
      `ECF_CHK(resp.fault, ROWS[i].fault)
      `ECF_CHK(resp.muted, ROWS[i].muted)
      `ECF_CHK(resp.base, (ROWS[i].act == 2'h1) ? 20'habcde : 20'h0)
      nfault += ROWS[i].fault;
    end
    $display("test decode table done");
    bus(1'h0, ecf_pkg::OFS_FCOUNT, 32'h0);
    `ECF_CHK(rd[15:0], 16'(nfault))
    bus(1'h0, ecf_pkg::OFS_LAST, 32'h0);
    `ECF_CHK(rd, 32'h0041_2345)
    bus(1'h0, ecf_pkg::OFS_STATUS, 32'h0);
    `ECF_CHK(rd[3:0], 4'hf)
    `ECF_CHK(irq_o, 1'h0)
    bus(1'h1, ecf_pkg::OFS_MASK, 32'h2);
    @(posedge sys_clk_i);
    `ECF_CHK(irq_o, 1'h1)
    bus(1'h1, ecf_pkg::OFS_STATUS, 32'hf);
    @(posedge sys_clk_i);
    `ECF_CHK(irq_o, 1'h0)
    bus(1'h1, ecf_pkg::OFS_ENTRY, 32'hffffffff);
    bus(1'h0, ecf_pkg::OFS_ENTRY, 32'h0);
    `ECF_CHK(rd, ecf_pkg::ENTRY_WMASK)
    $display("test status and interrupt done");
    id_only_capable_i <= 1'h0;
    repeat (6) @(posedge sys_clk_i);
    bus(1'h1, ecf_pkg::OFS_ENTRY, 32'h819);
    send(2'h0, 1'h1);
    `ECF_CHK(resp.action, ecf_pkg::ACT_BLOCK)
    @(posedge sys_clk_i);
    rst_n_i <= 1'h0;
    @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    bus(1'h0, ecf_pkg::OFS_ENTRY, 32'h0);
    `ECF_CHK(rd, 32'h0)
    $display("test capability and second reset done");
    end_of_test;
  end
endmodule : ecf_filter_bench
bind ecf_filter ecf_filter_checker i_ecf_filter_checker (.sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .req_i(req_i), .resp_o(resp_o));
